// ### ataw_pkg.sv
// Purpose: shared constants for the ata write and monitoring command block
// Assumes: byte-wide task file, 16-bit data words, one clock domain
// Notes:   register codes are the internal select values of tf_addr
package ataw_pkg;
  // task-file select codes
  localparam logic [2:0] TF_DATA   = 3'h0;
  localparam logic [2:0] TF_FEAT   = 3'h1; // features on write, error on read
  localparam logic [2:0] TF_COUNT  = 3'h2;
  localparam logic [2:0] TF_LBA_LO = 3'h3;
  localparam logic [2:0] TF_LBA_MD = 3'h4; // cylinder low
  localparam logic [2:0] TF_LBA_HI = 3'h5; // cylinder high
  localparam logic [2:0] TF_DEV    = 3'h6;
  localparam logic [2:0] TF_CMD    = 3'h7; // command on write, status on read
  // command codes
  localparam logic [7:0] CMD_WR28  = 8'h30;
  localparam logic [7:0] CMD_WR48  = 8'h34;
  localparam logic [7:0] CMD_MON   = 8'hB0;
  // monitoring subcommands carried in the feature register
  localparam logic [7:0] SUB_RDATA = 8'hD0;
  localparam logic [7:0] SUB_RTHR  = 8'hD1;
  localparam logic [7:0] SUB_ASAVE = 8'hD2;
  localparam logic [7:0] SUB_SAVE  = 8'hD3;
  localparam logic [7:0] SUB_OFFL  = 8'hD4;
  localparam logic [7:0] SUB_EN    = 8'hD8;
  localparam logic [7:0] SUB_DIS   = 8'hD9;
  localparam logic [7:0] SUB_STAT  = 8'hDA;
  // signatures in cylinder low / high
  localparam logic [7:0] KEY_LO    = 8'h4F;
  localparam logic [7:0] KEY_HI    = 8'hC2;
  localparam logic [7:0] FAIL_LO   = 8'hF4;
  localparam logic [7:0] FAIL_HI   = 8'h2C;
  localparam logic [7:0] ASAVE_ON  = 8'hF1;
  // default attribute thresholds, percent
  localparam logic [7:0] SPARE_THR = 8'h19; // 25 percent of spares
  localparam logic [7:0] ERASE_THR = 8'h01; // 1 percent of life left
  // counts
  localparam logic [16:0] SECT28_MAX = 17'h00100; // 256 sectors
  localparam logic [16:0] SECT48_MAX = 17'h10000; // 65536 sectors
  localparam int          SECT_WORDS = 256;       // 16-bit words per sector
  // error register bits
  localparam int ERRB_ABRT  = 2;
  localparam int ERRB_MEDIA = 6;
  // device control bit
  localparam int CTLB_HOB   = 7;
  // reset value of the working task-file bytes
  localparam logic [7:0] TF_RESET  = 8'h00;
  // command state machine, gray along idle-setup-drq-write-waitbuf
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_DRQ   = 3'b011,
    ST_WRITE = 3'b010,
    ST_WAIT  = 3'b110,
    ST_SBUSY = 3'b111,
    ST_DONE  = 3'b101
  } ataw_state_e;
endpackage

// ### ataw_wd_if.sv
// Purpose: carries sector words between the command core and word counter
// Assumes: one producer (core) and one counter module
// Notes:   clr restarts the word count at each new command
`timescale 1ns/1ns
interface ataw_wd_if #(parameter int DW = 16);
  logic          clr;       // restart word count
  logic          valid;     // host word accepted this cycle
  logic [DW-1:0] data;      // host word
  logic          sect_done; // last word of sector accepted
  logic          out_valid; // registered word toward media
  logic [DW-1:0] out_data;  // registered word toward media
  modport core (output clr, output valid, output data,
                input sect_done, input out_valid, input out_data);
  modport cnt  (input clr, input valid, input data,
                output sect_done, output out_valid, output out_data);
endinterface

// ### ataw_sect.sv
// Purpose: counts the words of one sector and registers them to media
// Assumes: valid is only raised while the core shows drq
// Notes:   sect_done is combinational so the core leaves drq at once
`timescale 1ns/1ns
module ataw_sect
  import ataw_pkg::*;
#(
  parameter int WORDS = SECT_WORDS
)(
  input  wire logic ref_clk,
  input  wire logic rstn,
  ataw_wd_if.cnt    wd
);
  localparam int CW = $clog2(WORDS);
  localparam logic [CW-1:0] LAST_W = CW'(WORDS - 1);

  logic [CW-1:0] cnt_q; // words taken in this sector

  // last word of the sector seen this cycle
  assign wd.sect_done = wd.valid && (cnt_q == LAST_W);

  // word counter, cleared per sector
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || wd.clr)
      cnt_q <= '0;
    else if (wd.valid)
      cnt_q <= wd.sect_done ? '0 : cnt_q + 1'b1;
  end

  // data passes through one register, no buffering beyond that
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      wd.out_valid <= 1'b0;
      wd.out_data  <= '0;
    end
    else
    begin
      wd.out_valid <= wd.valid;
      wd.out_data  <= wd.data;
    end
  end
endmodule

// ### ataw_core.sv
// Purpose: device-side write sector and monitoring command handling
// Assumes: host writes task file only while bsy is low; media acks sectors
// Notes:   attribute data content lives outside; reads complete with no data
//
// Behaviour
// - 28-bit write count zero means 256
// - write starts at loaded address, then increments
// - accept: bsy, then drq with bsy clear
// - no interrupt before first data block
// - between sectors bsy, then drq plus interrupt
// - after last sector bsy until completion interrupt
// - 28-bit error stops, failing address left readable
// - 48-bit write count zero means 65536
// - 48-bit write interrupts each data block after the first
// - 48-bit error reports full failing address
// - hob bit selects previous byte halves
// - feature value selects monitoring subcommand
// - unknown monitoring subcommand is aborted
// - enable/disable state kept nonvolatile
// - threshold crossed gives F4h, 2Ch
// - no threshold crossed gives 4Fh, C2h
// - spare or erase attribute crossing flags failure
// - autosave completes with no effect
// - save attributes: bsy, then interrupt
`timescale 1ns/1ns
module ataw_core
  import ataw_pkg::*;
#(
  parameter int WORDS = SECT_WORDS
)(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        tf_wr,       // task-file write strobe
  input  wire logic        tf_rd,       // task-file read strobe
  input  wire logic [2:0]  tf_addr,     // task-file select
  input  wire logic [7:0]  tf_wdata,
  output logic      [7:0]  tf_rdata,    // registered read data
  input  wire logic        ctl_wr,      // device control write strobe
  input  wire logic [7:0]  ctl_wdata,
  input  wire logic        wd_valid,    // host data word
  input  wire logic [15:0] wd_data,
  output logic             wd_ready,
  output logic             med_wr_req,  // sector write to media
  output logic      [47:0] med_lba,
  output logic             med_wvalid,
  output logic      [15:0] med_wdata,
  input  wire logic        med_done,    // one-cycle media answer
  input  wire logic        med_err,
  input  wire logic        med_ready,   // buffer takes next sector
  input  wire logic [7:0]  spare_attr,  // remaining spare, percent
  input  wire logic [7:0]  erase_attr,  // remaining life, percent
  input  wire logic        nv_mon_en,   // stored monitoring enable
  output logic             nv_wr,       // store monitoring enable
  output logic             nv_wdata,
  output logic             intrq,
  output logic             bsy,
  output logic             drq
);
  ataw_state_e state_q, state_d; // command sequencer
  logic [7:0]  cur_q [1:6];       // current bytes of task file
  logic [7:0]  prv_q [1:6];       // previous bytes for 48-bit use
  logic [7:0]  err_q;             // error register
  logic        hob_q;             // high-order byte select
  logic        is48_q;            // running command is 48-bit
  logic [16:0] rem_q;             // sectors still to write
  logic [47:0] lba_q;             // sector being written
  logic        intrq_q;
  logic        mon_en_q;          // monitoring enabled
  logic        nv_load_q;         // strap capture done
  logic        nv_wr_q;
  logic        nv_wdata_q;
  logic [7:0]  rdata_q;

  ataw_wd_if #(.DW(16)) wd ();

  // decode of the command write
  wire         cmd_go   = tf_wr && (tf_addr == TF_CMD) && (state_q == ST_IDLE);
  wire [7:0]   cmd      = tf_wdata;
  wire [7:0]   feat     = cur_q[TF_FEAT];
  wire         is_wr28  = (cmd == CMD_WR28);
  wire         is_wr48  = (cmd == CMD_WR48);
  wire         is_mon   = (cmd == CMD_MON);
  wire         is_write = is_wr28 || is_wr48;
  // known subcommand codes
  wire         sub_ok   = (feat == SUB_RDATA) || (feat == SUB_RTHR)
                       || (feat == SUB_ASAVE) || (feat == SUB_SAVE)
                       || (feat == SUB_OFFL)  || (feat == SUB_EN)
                       || (feat == SUB_DIS)   || (feat == SUB_STAT);
  // key bytes the host must place with every monitoring command
  wire         keys_ok  = (cur_q[TF_LBA_MD] == KEY_LO)
                       && (cur_q[TF_LBA_HI] == KEY_HI);
  // only enable is taken while monitoring is switched off
  wire         mon_ok   = is_mon && sub_ok && keys_ok
                       && (mon_en_q || (feat == SUB_EN));
  wire         cmd_abrt = cmd_go && !is_write && !mon_ok;
  // threshold crossed by either life attribute
  wire         thr_hit  = (spare_attr <= SPARE_THR)
                       || (erase_attr <= ERASE_THR);
  wire         last     = (rem_q == 17'h00001);
  wire         sect_ok  = (state_q == ST_WRITE) && med_done && !med_err;
  wire         sect_bad = (state_q == ST_WRITE) && med_done && med_err;

  // start address of a write, from the task file
  wire [47:0]  lba28_in = {20'h00000, cur_q[TF_DEV][3:0],
                           cur_q[TF_LBA_HI], cur_q[TF_LBA_MD],
                           cur_q[TF_LBA_LO]};
  wire [47:0]  lba48_in = {prv_q[TF_LBA_HI], prv_q[TF_LBA_MD],
                           prv_q[TF_LBA_LO], cur_q[TF_LBA_HI],
                           cur_q[TF_LBA_MD], cur_q[TF_LBA_LO]};
  wire [15:0]  cnt16    = {prv_q[TF_COUNT], cur_q[TF_COUNT]};
  wire [47:0]  lba_nxt  = lba_q + 48'h000000000001;

  // sector count with zero standing for the full range
  function automatic logic [16:0] sect_cnt(input logic w48,
                                           input logic [15:0] c);
    logic [16:0] r;
    r = 17'h00000;
    if (w48)
      r = (c == 16'h0000) ? SECT48_MAX : {1'b0, c};
    else
      r = (c[7:0] == 8'h00) ? SECT28_MAX : {9'h000, c[7:0]};
    return r;
  endfunction

  // status byte: bsy, ready, seek done, drq and error summary
  wire [7:0]   status   = {bsy, 1'b1, 1'b0, 1'b1, drq, 2'b00, |err_q};
  wire [7:0]   rd_mux   = (tf_addr == TF_CMD)  ? status :
                          (tf_addr == TF_FEAT) ? err_q  :
                          (tf_addr == TF_DATA) ? 8'h00  :
                          hob_q ? prv_q[tf_addr] : cur_q[tf_addr];
  // interrupt points: completion and each later buffer-ready
  wire         irq_set  = (state_q == ST_DONE)
                       || ((state_q == ST_WAIT) && med_ready);
  wire         irq_clr  = (tf_rd && (tf_addr == TF_CMD)) || cmd_go;

  // handshake outputs come straight from the state register
  assign bsy        = (state_q == ST_SETUP) || (state_q == ST_WRITE)
                   || (state_q == ST_WAIT)  || (state_q == ST_SBUSY)
                   || (state_q == ST_DONE);
  assign drq        = (state_q == ST_DRQ);
  assign wd_ready   = drq;
  assign wd.clr     = cmd_go;
  assign wd.valid   = wd_valid && drq;
  assign wd.data    = wd_data;
  assign med_wvalid = wd.out_valid;
  assign med_wdata  = wd.out_data;
  assign med_wr_req = (state_q == ST_WRITE);
  assign med_lba    = lba_q;
  assign intrq      = intrq_q;
  assign tf_rdata   = rdata_q;
  assign nv_wr      = nv_wr_q;
  assign nv_wdata   = nv_wdata_q;

  ataw_sect #(.WORDS(WORDS)) u_sect (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wd      (wd)
  );

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (cmd_go)
          state_d = is_write ? ST_SETUP :
                    (mon_ok && (feat == SUB_SAVE)) ? ST_SBUSY : ST_DONE;
      ST_SETUP: state_d = ST_DRQ;
      ST_DRQ:   if (wd.sect_done) state_d = ST_WRITE;
      ST_WRITE:
        if (med_done)
          state_d = (med_err || last) ? ST_DONE : ST_WAIT;
      ST_WAIT:  if (med_ready) state_d = ST_DRQ;
      ST_SBUSY: state_d = ST_DONE;
      ST_DONE:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // working address and remaining sectors of a write
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rem_q  <= 17'h00000;
      lba_q  <= 48'h000000000000;
      is48_q <= 1'b0;
    end
    else if (cmd_go && is_write)
    begin
      rem_q  <= sect_cnt(is_wr48, cnt16);
      lba_q  <= is_wr48 ? lba48_in : lba28_in;
      is48_q <= is_wr48;
    end
    else if (sect_ok)
    begin
      rem_q  <= rem_q - 17'h00001;
      lba_q  <= lba_nxt;
    end
  end

  // task file: host writes while bsy is low, device updates on return status and after each written sector but the last
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      for (int i = 1; i <= 6; i++)
      begin
        cur_q[i] <= TF_RESET;
        prv_q[i] <= TF_RESET;
      end
    end
    else if (tf_wr && !bsy && (tf_addr != TF_CMD) && (tf_addr != TF_DATA))
    begin
      // each write pushes the older byte into the previous half
      prv_q[tf_addr] <= cur_q[tf_addr];
      cur_q[tf_addr] <= tf_wdata;
    end
    else if (cmd_go && mon_ok && (feat == SUB_STAT))
    begin
      cur_q[TF_LBA_MD] <= thr_hit ? FAIL_LO : KEY_LO;
      cur_q[TF_LBA_HI] <= thr_hit ? FAIL_HI : KEY_HI;
    end
    else if (sect_ok && !last)
    begin
      // keep the next sector readable so an error leaves its address
      cur_q[TF_LBA_LO] <= lba_nxt[7:0];
      cur_q[TF_LBA_MD] <= lba_nxt[15:8];
      cur_q[TF_LBA_HI] <= lba_nxt[23:16];
      if (is48_q)
      begin
        prv_q[TF_LBA_LO] <= lba_nxt[31:24];
        prv_q[TF_LBA_MD] <= lba_nxt[39:32];
        prv_q[TF_LBA_HI] <= lba_nxt[47:40];
      end
      else
        cur_q[TF_DEV] <= {cur_q[TF_DEV][7:4], lba_nxt[27:24]};
    end
  end

  // error register, cleared by each new command
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || cmd_go)
      err_q <= cmd_abrt ? 8'(1 << ERRB_ABRT) : 8'h00;
    else if (sect_bad)
      err_q <= 8'(1 << ERRB_MEDIA);
  end

  // hob follows the control write; any task-file access drops it
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      hob_q <= 1'b0;
    else if (ctl_wr)
      hob_q <= ctl_wdata[CTLB_HOB];
    else if (tf_wr || tf_rd)
      hob_q <= 1'b0;
  end

  // interrupt line: a new event beats a status read in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      intrq_q <= 1'b0;
    else if (irq_set)
      intrq_q <= 1'b1;
    else if (irq_clr)
      intrq_q <= 1'b0;
  end

  // registered read data
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else if (tf_rd)
      rdata_q <= rd_mux;
  end

  // monitoring enable: stored value caught once after reset release,
  // then switched by enable and disable, each change written back
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mon_en_q   <= 1'b0;
      nv_load_q  <= 1'b0;
      nv_wr_q    <= 1'b0;
      nv_wdata_q <= 1'b0;
    end
    else
    begin
      nv_load_q <= 1'b1;
      nv_wr_q   <= cmd_go && mon_ok
                && ((feat == SUB_EN) || (feat == SUB_DIS));
      if (!nv_load_q)
        mon_en_q <= nv_mon_en;
      else if (cmd_go && mon_ok && (feat == SUB_EN))
      begin
        mon_en_q   <= 1'b1;
        nv_wdata_q <= 1'b1;
      end
      else if (cmd_go && mon_ok && (feat == SUB_DIS))
      begin
        mon_en_q   <= 1'b0;
        nv_wdata_q <= 1'b0;
      end
      // autosave and the other no-op codes change nothing here
    end
  end

  // checks on the sequencer
  a_first_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == ST_SETUP |=> drq && !bsy && !intrq_q)
    else $error("interrupt or busy at first data block");
  a_accept_bsy: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && is_write |=> bsy && !drq ##1 drq && !bsy)
    else $error("write accept handshake wrong");
  a_sect_busy: assert property (@(posedge ref_clk) disable iff (!rstn)
    drq && wd.sect_done |=> bsy && !drq && med_wr_req)
    else $error("sector end did not raise busy");
  a_next_irq: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == ST_WAIT && med_ready |=> drq && intrq_q)
    else $error("next block without interrupt");
  a_last_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    sect_ok && last |=> (bsy && !drq) ##1 (!bsy && intrq_q))
    else $error("completion sequence wrong");
  a_count28: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && is_wr28 && cur_q[TF_COUNT] == 8'h00 |=> rem_q == 17'h00100)
    else $error("28-bit zero count not 256");
  a_count48: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && is_wr48 && cnt16 == 16'h0000 |=> rem_q == 17'h10000)
    else $error("48-bit zero count not 65536");
  a_start_lba: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && is_wr48 |=> lba_q == $past(lba48_in))
    else $error("write start address wrong");
  a_err_stop: assert property (@(posedge ref_clk) disable iff (!rstn)
    sect_bad |=> state_q == ST_DONE && err_q[ERRB_MEDIA]
      && cur_q[TF_LBA_LO] == $past(lba_q[7:0]))
    else $error("failed sector not reported");
  a_stat_sig: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && mon_ok && feat == SUB_STAT |=>
      cur_q[TF_LBA_HI] == ($past(thr_hit) ? FAIL_HI : KEY_HI))
    else $error("return status signature wrong");
  a_sub_abort: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && is_mon && !sub_ok |=> err_q[ERRB_ABRT] ##1 intrq_q)
    else $error("unknown subcommand not aborted");
  a_save_irq: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && mon_ok && feat == SUB_SAVE |=> bsy [*2] ##1 !bsy && intrq_q)
    else $error("save attributes sequence wrong");

  c_write_done: cover property (@(posedge ref_clk) disable iff (!rstn)
    sect_ok && last ##2 intrq_q);
  c_next_sect: cover property (@(posedge ref_clk) disable iff (!rstn)
    state_q == ST_WAIT && med_ready);
  c_media_err: cover property (@(posedge ref_clk) disable iff (!rstn)
    sect_bad);
  c_stat_fail: cover property (@(posedge ref_clk) disable iff (!rstn)
    cmd_go && mon_ok && feat == SUB_STAT && thr_hit);
endmodule

// ### ataw_host_bfm.sv
// Purpose: host side mover of sector words toward the device
// Assumes: words are offered only while the device shows drq
// Notes:   a released bus shows the inverted count, never stale data
`timescale 1ns/1ns
module ataw_host_bfm (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        wd_ready,
  output logic             wd_valid,
  output logic      [15:0] wd_data
);
  logic [15:0] cnt_q; // value of the next word to send

  // count words the device has taken
  always @(posedge ref_clk)
  begin
    if (!rstn)
      cnt_q <= 16'h0000;
    else if (wd_valid && wd_ready)
      cnt_q <= cnt_q + 16'h0001;
  end

  // random stalls, and no word while wd_ready is low
  always @(negedge ref_clk)
  begin
    wd_valid <= rstn && wd_ready && ($urandom_range(3) != 0);
    wd_data  <= (rstn && wd_ready) ? cnt_q : ~cnt_q;
  end
endmodule

// ### ata_write_and_smart_commands_tb.sv
// Purpose: self-checking bench for sector writes and monitoring commands
// Assumes: four-word sectors keep the long sector counts cheap
// Notes:   each read queues its expected byte; a watcher compares it
`timescale 1ns/1ns
module ata_write_and_smart_commands_tb;
  import ataw_pkg::*;
  localparam int W = 4; // words per sector, short for speed
  logic        ref_clk, rstn, tf_wr, tf_rd, ctl_wr, wd_valid, wd_ready;
  logic        med_wr_req, med_wvalid, med_done, med_err, med_ready;
  logic        nv_mon_en, nv_wr, nv_wdata, intrq, bsy, drq;
  logic [2:0]  tf_addr;
  logic [7:0]  tf_wdata, tf_rdata, ctl_wdata, spare_attr, erase_attr;
  logic [15:0] wd_data, med_wdata;
  logic [47:0] med_lba;
  logic [7:0]  rd_q[$];    // expected read bytes, oldest first
  logic [15:0] exp_w;      // next word expected toward media
  int          num_errors, cmp_count, cyc;

  ataw_core #(.WORDS(W)) ataw_core_i (.ref_clk, .rstn, .tf_wr, .tf_rd,
    .tf_addr, .tf_wdata, .tf_rdata, .ctl_wr, .ctl_wdata, .wd_valid,
    .wd_data, .wd_ready, .med_wr_req, .med_lba, .med_wvalid, .med_wdata,
    .med_done, .med_err, .med_ready, .spare_attr, .erase_attr,
    .nv_mon_en, .nv_wr, .nv_wdata, .intrq, .bsy, .drq);
  ataw_host_bfm ataw_host_bfm_i (.ref_clk, .rstn, .wd_ready, .wd_valid,
    .wd_data);

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // tasks enter and leave at a falling edge; strobes last one cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    tf_addr  = a;
    tf_wdata = d;
    tf_wr    = 1'b1;
    @(negedge ref_clk);
    tf_wr    = 1'b0;
  endtask

  // a write and one idle cycle, so two strobes never abut
  task automatic wrg(input logic [2:0] a, input logic [7:0] d);
    wr(a, d);
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    tf_addr = a;
    tf_rd   = 1'b1;
    @(negedge ref_clk);
    tf_rd   = 1'b0;
    @(negedge ref_clk);
  endtask

  // bounded wait: 0 media request, 1 drq, 2 busy cleared
  task automatic wt(input int k);
    for (int i = 0; i < 60; i++)
    begin
      if ((k == 0 && med_wr_req === 1'b1) || (k == 1 && drq === 1'b1)
          || (k == 2 && bsy === 1'b0))
        break;
      @(negedge ref_clk);
    end
  endtask

  // one write command of n sectors, media failing at sector e
  task automatic run(input bit w48, input logic [47:0] lb, input int n,
                     input logic [15:0] cnt, input int e);
    logic [47:0] a;
    for (int i = 0; i < 3; i++)
    begin
      if (w48)
        wrg(3'(3 + i), lb[24 + 8 * i +: 8]);
      wrg(3'(3 + i), lb[8 * i +: 8]);
    end
    wrg(TF_DEV, w48 ? 8'hE0 : {4'hE, lb[27:24]});
    if (w48)
      wrg(TF_COUNT, cnt[15:8]);
    wrg(TF_COUNT, cnt[7:0]);
    wr(TF_CMD, w48 ? CMD_WR48 : CMD_WR28);
    chk({bsy, drq}, 2'b10);
    @(negedge ref_clk);
    chk({bsy, drq, intrq}, 3'b010);
    for (int s = 0; s < n; s++)
    begin
      if (s > 0)
      begin
        wt(1);
        chk({bsy, drq, intrq}, 3'b011);
        rd(TF_CMD, 8'h58); // status read also clears the interrupt
      end
      wt(0);
      a = lb + 48'(s);
      chk({bsy, drq}, 2'b10);
      chk(med_lba, a);
      med_ready = 1'b0;
      med_done  = 1'b1;
      med_err   = (s == e);
      @(negedge ref_clk);
      med_done  = 1'b0;
      med_err   = 1'b0;
      if (s == e || s == n - 1)
        break;
      repeat ($urandom_range(3)) @(negedge ref_clk);
      chk({bsy, drq}, 2'b10);
      med_ready = 1'b1;
    end
    chk(bsy, 1'b1);
    wt(2);
    chk(intrq, 1'b1);
    rd(TF_CMD, e < 0 ? 8'h50 : 8'h51);
    if (e >= 0)
    begin
      a = lb + 48'(e);
      rd(TF_FEAT, 8'h40);
      rd(TF_LBA_LO, a[7:0]);
      rd(TF_LBA_HI, a[23:16]);
      ctl_wdata = 8'h80;
      ctl_wr    = 1'b1;
      @(negedge ref_clk);
      ctl_wr    = 1'b0;
      if (w48)
        rd(TF_LBA_LO, a[31:24]);
    end
    $display("test write n=%0d fail=%0d done", n, e);
  endtask

  // one monitoring subcommand with given attributes
  task automatic mon(input logic [7:0] f, input logic [7:0] sp,
                     input logic [7:0] er, input bit ab);
    bit fail;
    int n;
    fail = (f == SUB_STAT) && !ab && (sp <= 8'h19 || er <= 8'h01);
    spare_attr = sp;
    erase_attr = er;
    wrg(TF_FEAT, f);
    wrg(TF_COUNT, ASAVE_ON);
    wrg(TF_LBA_MD, KEY_LO);
    wrg(TF_LBA_HI, KEY_HI);
    wr(TF_CMD, CMD_MON);
    if ((f == SUB_EN || f == SUB_DIS) && !ab)
      chk({nv_wr, nv_wdata}, {1'b1, f == SUB_EN});
    n = 1;
    while (bsy === 1'b1 && n < 9)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(48'(n), (f == SUB_SAVE && !ab) ? 48'h3 : 48'h2);
    chk(intrq, 1'b1);
    rd(TF_CMD, ab ? 8'h51 : 8'h50);
    if (ab)
      rd(TF_FEAT, 8'h04);
    rd(TF_LBA_MD, fail ? FAIL_LO : KEY_LO);
    rd(TF_LBA_HI, fail ? FAIL_HI : KEY_HI);
    $display("test monitor %h done", f);
  endtask

  // read data a cycle after its strobe
  always @(posedge ref_clk)
  begin
    if (tf_rd === 1'b1)
    begin
      @(negedge ref_clk);
      chk(tf_rdata, rd_q.pop_front());
    end
  end

  // media words follow host order; hang guard
  always @(negedge ref_clk)
  begin
    if (med_wvalid === 1'b1)
    begin
      chk(med_wdata, exp_w);
      exp_w++;
    end
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end

  initial
  begin
    {tf_wr, tf_rd, ctl_wr, med_done, med_err, med_ready} = 6'h00;
    {tf_addr, tf_wdata, ctl_wdata} = 19'h00000;
    {spare_attr, erase_attr} = 16'h6464;
    nv_mon_en  = 1'b1;
    rstn       = 1'b0;
    exp_w      = 16'h0000;
    num_errors = 0;
    cmp_count  = 0;
    cyc        = 0;
    void'($urandom(32'hC243));
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({bsy, drq, intrq}, 3'b000);
    run(0, 48'($urandom) & 48'h0FFF_FFFF, 2, 16'h0002, -1);
    run(0, 48'($urandom) & 48'h0FFF_FFFF, 256, 16'h0000, -1);
    run(0, 48'($urandom) & 48'h0FFF_FFFF, 3, 16'h0003, 1);
    // zero count means 65536; the failing second sector ends it early
    run(1, {16'($urandom), 24'($urandom), 8'hFF}, 2, 16'h0000, 1);
    run(1, {$urandom, 16'($urandom)}, 257, 16'h0101, -1);
    mon(SUB_RDATA, 8'h64, 8'h64, 1'b0);
    mon(SUB_RTHR, 8'h64, 8'h64, 1'b0);
    mon(SUB_ASAVE, 8'h64, 8'h64, 1'b0);
    mon(SUB_SAVE, 8'h64, 8'h64, 1'b0);
    mon(SUB_OFFL, 8'h64, 8'h64, 1'b0);
    mon(SUB_STAT, 8'h1A, 8'h02, 1'b0);
    mon(SUB_STAT, 8'h19, 8'h64, 1'b0);
    mon(SUB_STAT, 8'h64, 8'h01, 1'b0);
    mon(8'hD5, 8'h64, 8'h64, 1'b1);
    mon(SUB_DIS, 8'h64, 8'h64, 1'b0);
    mon(SUB_RDATA, 8'h64, 8'h64, 1'b1);
    mon(SUB_EN, 8'h64, 8'h64, 1'b0);
    mon(SUB_STAT, 8'h64, 8'h64, 1'b0);
    // second reset with a stored disable: monitoring must stay off
    nv_mon_en = 1'b0;
    rstn      = 1'b0;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({bsy, drq, intrq}, 3'b000);
    mon(SUB_STAT, 8'h64, 8'h64, 1'b1);
    tally_and_finish;
  end
endmodule
